// file: rtl/lre_consts.svh
`ifndef LRE_CONSTS_SVH
`define LRE_CONSTS_SVH
// ----------------------------------------
// Register word indexes (byte address / 4)
// ----------------------------------------
`define LRE_IDX_CTRL 10'h000
`define LRE_IDX_STATUS 10'h001
`define LRE_IDX_SCANS 10'h002
`define LRE_IDX_COIL_HI 6'h02
`define LRE_IDX_PROG_HI 2'h1
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LRE_CTRL_RUN 0
`define LRE_STAT_ACTIVE 0
`define LRE_STAT_FAULT 1
`define LRE_STAT_RETAIN 2
`define LRE_STAT_PWR 3
`define LRE_RST_RUN 1'h0
`define LRE_INSTR_OP_HI 15
`define LRE_INSTR_OP_LO 12
`define LRE_INSTR_REF_HI 8
// ----------------------------------------
// Coil references, last program address and stack depth
// ----------------------------------------
`define LRE_REF_RET_LO 9'h0C0
`define LRE_REF_RET_HI 9'h0FA
`define LRE_REF_RET_EN 9'h0FB
`define LRE_REF_OUT_DIS 9'h0FE
`define LRE_REF_SPEC_HI 9'h0FF
`define LRE_REF_TC_LO 9'h180
`define LRE_REF_TC_HI 9'h193
`define LRE_REF_OUT_LO 9'h010
`define LRE_REF_OUT_BLK 5'h01
`define LRE_REF_LAST 9'h1FF
`define LRE_PC_LAST 8'hFF
`define LRE_STACK_DEPTH 4'h8
`endif

// file: rtl/lre_core.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "lre_consts.svh"
module lre_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Field inputs and power sense
  input wire logic [15:0] in_i,
  input wire logic pwr_ok_i,
  // Field outputs
  output logic [15:0] phys_out_o,
  // Timer and counter commands
  output logic tc_valid_o,
  output logic [8:0] tc_ref_o,
  output logic tc_power_o,
  output logic tc_enable_o
);
  import lre_pkg::*;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] prog [0:255];
  logic [511:0] coil;
  logic [15:0] unmasked;
  lre_state_t state;
  logic [7:0] pc;
  logic [8:0] restore_idx;
  logic acc;
  logic rung_open;
  logic run;
  logic fault;
  logic [31:0] scans;
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic is_retentive(input logic [8:0] r,
                                        input logic en);
    logic special;
    logic tc;
    logic reserved;
    special = (r >= `LRE_REF_RET_EN) && (r <= `LRE_REF_SPEC_HI);
    tc = (r >= `LRE_REF_TC_LO) && (r <= `LRE_REF_TC_HI);
    reserved = (r >= `LRE_REF_RET_LO) && (r <= `LRE_REF_RET_HI);
    is_retentive = special | tc | (reserved & en);
  endfunction
  function automatic logic is_out_ref(input logic [8:0] r);
    is_out_ref = (r[8:4] == `LRE_REF_OUT_BLK);
  endfunction
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [16:0] sync1;
  logic [16:0] sync2;
  logic [16:0] sync3;
  logic [16:0] stable;
  // A level counts only once the second and third stage agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 17'h00000;
      sync2 <= 17'h00000;
      sync3 <= 17'h00000;
      stable <= 17'h00000;
    end else begin
      sync1 <= {pwr_ok_i, in_i};
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= (sync2 & sync3) | (stable & (sync2 | sync3));
    end
  end
  wire pwr_ok = stable[16];
  wire [15:0] in_stable = stable[15:0];
  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire [15:0] instr = prog[pc];
  wire [3:0] op_raw = instr[`LRE_INSTR_OP_HI:`LRE_INSTR_OP_LO];
  wire lre_op_t op = lre_op_t'(op_raw);
  wire [8:0] ref_idx = instr[`LRE_INSTR_REF_HI:0];
  wire exec = (state == LRE_ST_EXEC);
  wire [15:0] prog0 = prog[0];
  wire lre_op_t op0 = lre_op_t'(prog0[`LRE_INSTR_OP_HI:`LRE_INSTR_OP_LO]);
  wire retain_en = ((op0 == LRE_OP_OUT) || (op0 == LRE_OP_SET)) &&
                   (prog0[`LRE_INSTR_REF_HI:0] == `LRE_REF_RET_EN);
  // Contacts read inputs below the output range, else coil memory
  wire contact = (ref_idx[8:4] == 5'h00) ? in_stable[ref_idx[3:0]] :
                 coil[ref_idx];
  wire is_begin = (op == LRE_OP_RUNG_BEGIN) ||
                  (op == LRE_OP_RUNG_BEGIN_NOT);
  wire is_join = (op == LRE_OP_SERIES_GROUP_JOIN) ||
                 (op == LRE_OP_PARALLEL_GROUP_JOIN);
  // Timer and counter coils end a rung like any other coil
  wire is_coil = (op == LRE_OP_OUT) || (op == LRE_OP_SET_OUT) ||
                 (op == LRE_OP_SET) || (op == LRE_OP_CLEAR) ||
                 (op == LRE_OP_TIMER_COUNTER);
  wire scan_done = exec && ((op == LRE_OP_END) || (pc == `LRE_PC_LAST));
  // ----------------------------------------
  // Group and permit stacks
  // ----------------------------------------
  logic grp_top;
  logic grp_over;
  logic grp_under;
  logic mp_top;
  logic [3:0] mp_depth;
  logic mp_over;
  logic mp_under;
  wire scan_start = (state == LRE_ST_IDLE) && run;
  wire grp_push = exec && is_begin && rung_open;
  wire grp_pop = exec && is_join;
  wire grp_clear = scan_start || (exec && is_coil);
  // The rail is the sub-rail of the innermost open permit region
  wire rail = (mp_depth == 4'h0) ? 1'b1 : mp_top;
  wire drive = acc & rail;
  wire mp_push = exec && (op == LRE_OP_MASTER_PERMIT_OPEN);
  wire mp_pop = exec && (op == LRE_OP_MASTER_PERMIT_CLOSE);
  lre_stack u_grp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(grp_clear),
    .push_i(grp_push),
    .pop_i(grp_pop),
    .data_i(acc),
    .top_o(grp_top),
    .depth_o(),
    .overflow_o(grp_over),
    .underflow_o(grp_under)
  );
  // Pushing acc gated by the rail makes inner regions need all outers
  lre_stack u_mp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(scan_start),
    .push_i(mp_push),
    .pop_i(mp_pop),
    .data_i(drive),
    .top_o(mp_top),
    .depth_o(mp_depth),
    .overflow_o(mp_over),
    .underflow_o(mp_under)
  );
  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  logic next_acc;
  always_comb begin
    next_acc = acc;
    case (op)
      LRE_OP_RUNG_BEGIN: next_acc = contact;
      LRE_OP_RUNG_BEGIN_NOT: next_acc = ~contact;
      LRE_OP_SERIES: next_acc = acc & contact;
      LRE_OP_SERIES_NOT: next_acc = acc & ~contact;
      LRE_OP_PARALLEL: next_acc = acc | contact;
      LRE_OP_PARALLEL_NOT: next_acc = acc | ~contact;
      LRE_OP_SERIES_GROUP_JOIN: next_acc = acc & grp_top;
      LRE_OP_PARALLEL_GROUP_JOIN: next_acc = acc | grp_top;
      default: next_acc = acc;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || scan_start) begin
      acc <= 1'b0;
      rung_open <= 1'b0;
    end else if (exec) begin
      acc <= next_acc;
      rung_open <= is_begin | (rung_open & ~is_coil & ~mp_push & ~mp_pop);
    end
  end
  // ----------------------------------------
  // Coil memory write port
  // ----------------------------------------
  wire restoring = (state == LRE_ST_RESTORE);
  wire latch_we = ((op == LRE_OP_SET) || (op == LRE_OP_CLEAR)) && drive;
  wire out_we = (op == LRE_OP_OUT) || (op == LRE_OP_SET_OUT);
  wire coil_we = restoring ? ~is_retentive(restore_idx, retain_en) :
                 exec && (out_we || latch_we);
  wire [8:0] coil_widx = restoring ? restore_idx : ref_idx;
  // Set writes one, clear writes zero; program order decides the winner
  wire coil_wdat = restoring ? 1'b0 :
                   (op == LRE_OP_SET) ? 1'b1 :
                   (op == LRE_OP_CLEAR) ? 1'b0 :
                   drive;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coil <= 512'h0;
    end else if (coil_we) begin
      coil[coil_widx] <= coil_wdat;
    end
  end
  // Output coils remember which form of output last wrote them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unmasked <= 16'h0000;
    end else if (exec && out_we && is_out_ref(ref_idx)) begin
      unmasked[ref_idx[3:0]] <= (op == LRE_OP_SET_OUT);
    end
  end
  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  lre_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      LRE_ST_OFF: next_state = pwr_ok ? LRE_ST_RESTORE : LRE_ST_OFF;
      LRE_ST_RESTORE:
        next_state = (restore_idx == `LRE_REF_LAST) ? LRE_ST_IDLE :
                     LRE_ST_RESTORE;
      LRE_ST_IDLE: next_state = run ? LRE_ST_EXEC : LRE_ST_IDLE;
      LRE_ST_EXEC: next_state = scan_done ? LRE_ST_OUTPUT : LRE_ST_EXEC;
      LRE_ST_OUTPUT: next_state = run ? LRE_ST_EXEC : LRE_ST_IDLE;
      default: next_state = LRE_ST_OFF;
    endcase
    if (!pwr_ok) begin
      next_state = LRE_ST_OFF;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= LRE_ST_OFF;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || (state != LRE_ST_RESTORE)) begin
      restore_idx <= 9'h000;
    end else begin
      restore_idx <= restore_idx + 9'h001;
    end
  end
  // Each scan starts at address zero and walks upward
  always_ff @(posedge clk_i) begin
    if (rst_i || !exec) begin
      pc <= 8'h00;
    end else if (!scan_done) begin
      pc <= pc + 8'h01;
    end
  end
  // Output image is applied once per scan, after the last instruction
  wire [15:0] out_coils = coil[`LRE_REF_OUT_LO +: 16];
  wire [15:0] out_gate = unmasked | {16{~coil[`LRE_REF_OUT_DIS]}};
  always_ff @(posedge clk_i) begin
    if (rst_i || (state == LRE_ST_OFF)) begin
      phys_out_o <= 16'h0000;
    end else if (state == LRE_ST_OUTPUT) begin
      phys_out_o <= out_coils & out_gate;
    end
  end
  // Timers see the rail as enable: low resets timers, freezes counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_valid_o <= 1'b0;
      tc_ref_o <= 9'h000;
      tc_power_o <= 1'b0;
      tc_enable_o <= 1'b0;
    end else begin
      tc_valid_o <= exec && (op == LRE_OP_TIMER_COUNTER);
      if (exec && (op == LRE_OP_TIMER_COUNTER)) begin
        tc_ref_o <= ref_idx;
        tc_power_o <= drive;
        tc_enable_o <= rail;
      end
    end
  end
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire [9:0] idx = wb_adr_i[11:2];
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire hit_prog = (idx[9:8] == `LRE_IDX_PROG_HI);
  wire hit_coil = (idx[9:4] == `LRE_IDX_COIL_HI);
  wire fault_set = grp_over | grp_under | mp_over | mp_under;
  wire fault_clr = wr && (idx == `LRE_IDX_STATUS) && wb_sel_i[0] &&
                   wb_dat_i[`LRE_STAT_FAULT];
  wire [15:0] prog_rd = prog[idx[7:0]];
  wire [31:0] status = {28'h0, pwr_ok, retain_en, fault, exec};
  wire [31:0] rd_data = (idx == `LRE_IDX_CTRL) ? {31'h0, run} :
                        (idx == `LRE_IDX_STATUS) ? status :
                        (idx == `LRE_IDX_SCANS) ? scans :
                        hit_coil ? coil[{idx[3:0], 5'h00} +: 32] :
                        hit_prog ? {16'h0000, prog_rd} : 32'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= `LRE_RST_RUN;
    end else if (wr && (idx == `LRE_IDX_CTRL) && wb_sel_i[0]) begin
      run <= wb_dat_i[`LRE_CTRL_RUN];
    end
  end
  // A fault raised in the clearing cycle stays set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else begin
      fault <= fault_set | (fault & ~fault_clr);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scans <= 32'h0;
    end else if (state == LRE_ST_OUTPUT) begin
      scans <= scans + 32'h1;
    end
  end
  // Program memory has no reset; software loads it before setting run
  always_ff @(posedge clk_i) begin
    if (wr && hit_prog && wb_sel_i[0]) begin
      prog[idx[7:0]][7:0] <= wb_dat_i[7:0];
    end
    if (wr && hit_prog && wb_sel_i[1]) begin
      prog[idx[7:0]][15:8] <= wb_dat_i[15:8];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_series_join;
    @(posedge clk_i) disable iff (rst_i)
    exec && (op == LRE_OP_SERIES_GROUP_JOIN) |=>
      acc == ($past(acc) & $past(grp_top));
  endproperty
  a_series_join: assert property (p_series_join)
    else $error("series join result wrong");
  property p_parallel_join;
    @(posedge clk_i) disable iff (rst_i)
    exec && (op == LRE_OP_PARALLEL_GROUP_JOIN) |=>
      acc == ($past(acc) | $past(grp_top));
  endproperty
  a_parallel_join: assert property (p_parallel_join)
    else $error("parallel join result wrong");
  property p_restore_clear;
    @(posedge clk_i) disable iff (rst_i)
    restoring && !is_retentive(restore_idx, retain_en) |=>
      !coil[$past(restore_idx)];
  endproperty
  a_restore_clear: assert property (p_restore_clear)
    else $error("non-retentive coil survived power return");
  property p_keep_special;
    @(posedge clk_i) disable iff (rst_i)
    restoring && (restore_idx == `LRE_REF_OUT_DIS) |=>
      coil[`LRE_REF_OUT_DIS] == $past(coil[`LRE_REF_OUT_DIS]);
  endproperty
  a_keep_special: assert property (p_keep_special)
    else $error("special coil lost at power return");
  property p_off_outputs;
    @(posedge clk_i) disable iff (rst_i)
    (state == LRE_ST_OFF) ##1 (state == LRE_ST_OFF) |-> phys_out_o == 16'h0;
  endproperty
  a_off_outputs: assert property (p_off_outputs)
    else $error("outputs driven while power absent");
  property p_set_latch;
    @(posedge clk_i) disable iff (rst_i)
    exec && (op == LRE_OP_SET) && drive |=> coil[$past(ref_idx)];
  endproperty
  a_set_latch: assert property (p_set_latch)
    else $error("set did not turn coil on");
  property p_clear_latch;
    @(posedge clk_i) disable iff (rst_i)
    exec && (op == LRE_OP_CLEAR) && drive |=> !coil[$past(ref_idx)];
  endproperty
  a_clear_latch: assert property (p_clear_latch)
    else $error("clear did not turn coil off");
  property p_permit_off;
    @(posedge clk_i) disable iff (rst_i)
    exec && (op == LRE_OP_OUT) && !rail |=> !coil[$past(ref_idx)];
  endproperty
  a_permit_off: assert property (p_permit_off)
    else $error("coil on inside unpowered permit region");
  property p_nest;
    @(posedge clk_i) disable iff (rst_i)
    mp_push && !rail && (mp_depth < `LRE_STACK_DEPTH) |=> !rail;
  endproperty
  a_nest: assert property (p_nest)
    else $error("inner permit enabled under closed outer");
  property p_disable;
    @(posedge clk_i) disable iff (rst_i)
    (state == LRE_ST_OUTPUT) && coil[`LRE_REF_OUT_DIS] |=>
      (phys_out_o & ~$past(unmasked)) == 16'h0;
  endproperty
  a_disable: assert property (p_disable)
    else $error("masked output driven while disabled");
  property p_unmasked;
    @(posedge clk_i) disable iff (rst_i)
    (state == LRE_ST_OUTPUT) && pwr_ok |=>
      (phys_out_o & $past(unmasked)) == ($past(out_coils) & $past(unmasked));
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("unmasked output not following coil");
  property p_ascend;
    @(posedge clk_i) disable iff (rst_i)
    exec && !scan_done && pwr_ok |=> exec && (pc == $past(pc) + 8'h01);
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("scan did not advance to next address");
endmodule

// file: rtl/lre_pkg.sv
package lre_pkg;
  // ----------------------------------------
  // Instruction opcodes, erased memory ends the scan
  // ----------------------------------------
  typedef enum logic [3:0] {
    LRE_OP_END = 4'h0,
    LRE_OP_RUNG_BEGIN = 4'h1,
    LRE_OP_RUNG_BEGIN_NOT = 4'h2,
    LRE_OP_SERIES = 4'h3,
    LRE_OP_SERIES_NOT = 4'h4,
    LRE_OP_PARALLEL = 4'h5,
    LRE_OP_PARALLEL_NOT = 4'h6,
    LRE_OP_SERIES_GROUP_JOIN = 4'h7,
    LRE_OP_PARALLEL_GROUP_JOIN = 4'h8,
    LRE_OP_OUT = 4'h9,
    LRE_OP_SET_OUT = 4'hA,
    LRE_OP_SET = 4'hB,
    LRE_OP_CLEAR = 4'hC,
    LRE_OP_MASTER_PERMIT_OPEN = 4'hD,
    LRE_OP_MASTER_PERMIT_CLOSE = 4'hE,
    LRE_OP_TIMER_COUNTER = 4'hF
  } lre_op_t;
  // ----------------------------------------
  // Scan sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LRE_ST_OFF = 3'h0,
    LRE_ST_RESTORE = 3'h1,
    LRE_ST_IDLE = 3'h2,
    LRE_ST_EXEC = 3'h3,
    LRE_ST_OUTPUT = 3'h4
  } lre_state_t;
endpackage

// file: rtl/lre_stack.sv
`timescale 1ns/10ps
`include "lre_consts.svh"
module lre_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stack control
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic data_i,
  // Stack state
  output logic top_o,
  output logic [3:0] depth_o,
  output logic overflow_o,
  output logic underflow_o
);
  import lre_pkg::*;
  logic [7:0] bits;
  wire full = (depth_o == `LRE_STACK_DEPTH);
  wire empty = (depth_o == 4'h0);
  assign top_o = bits[0];
  assign overflow_o = push_i & full;
  assign underflow_o = pop_i & empty;
  // A push beyond the last level is dropped, the fault flag reports it
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      bits <= 8'h00;
      depth_o <= 4'h0;
    end else if (push_i && !full) begin
      bits <= {bits[6:0], data_i};
      depth_o <= depth_o + 4'h1;
    end else if (pop_i && !empty) begin
      bits <= {1'b0, bits[7:1]};
      depth_o <= depth_o - 4'h1;
    end
  end
  property p_depth_bound;
    @(posedge clk_i) disable iff (rst_i)
    depth_o <= `LRE_STACK_DEPTH;
  endproperty
  a_depth_bound: assert property (p_depth_bound)
    else $error("push-down stack deeper than eight");
endmodule

// file: testbench/lre_core_test.sv
`timescale 1ns/10ps
module lre_core_test;
  import lre_pkg::*;
  logic clk_i = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, pwr, tc_v, tc_p, tc_e;
  logic [15:0] in_w, phys, seen;
  logic [8:0] tc_r;
  logic [15:0] want = 16'h0000;
  logic pwr_want = 1'b1;
  logic tc_en = 1'b0;
  logic tc_pw = 1'b0;
  logic [8:0] tc_rf = 9'h000;
  int bad_count = 0;
  int samples_checked = 0;
  logic [15:0] prog [38] = '{16'h90FB, 16'h1000, 16'h3001, 16'h1002,
    16'h5003, 16'h7000, 16'h9010, 16'h1000, 16'h1001, 16'h8000, 16'h9011,
    16'h1004, 16'hB0C0, 16'h1005, 16'hC0C0, 16'h10C0, 16'h9012, 16'h20C0,
    16'h9013, 16'h1006, 16'hD000, 16'h1007, 16'h9014, 16'h100D, 16'hF180,
    16'h100A, 16'hD000, 16'h100B, 16'h9016, 16'hE000, 16'hE000, 16'h100C,
    16'h9017, 16'h1008, 16'h90FE, 16'h1009, 16'hA015, 16'h0000};

  always #20 clk_i = ~clk_i;

  lre_core i_dut (
    .clk_i(clk_i), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wen), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .in_i(in_w), .pwr_ok_i(pwr),
    .phys_out_o(phys), .tc_valid_o(tc_v), .tc_ref_o(tc_r),
    .tc_power_o(tc_p), .tc_enable_o(tc_e)
  );

  lre_field_io i_field (
    .clk_i(clk_i), .want_i(want), .pwr_want_i(pwr_want),
    .phys_i(phys), .in_o(in_w), .pwr_ok_o(pwr), .seen_o(seen)
  );

  always @(posedge clk_i) begin
    if (tc_v === 1'b1) begin
      tc_pw <= tc_p;
      tc_rf <= tc_r;
      tc_en <= tc_e;
    end
  end

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    // No local limit: a missing ack is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counting scans beats fixed waits: scan length follows the program
  task automatic scans(input int k);
    logic [31:0] s0, s;
    wb(1'b0, 12'h008, 32'h0, s0);
    do begin
      wb(1'b0, 12'h008, 32'h0, s);
    end while (s - s0 < k);
  endtask

  function automatic logic [15:0] expect_out(input logic [15:0] v,
                                             input logic l);
    logic [15:0] o;
    o = 16'h0000;
    o[0] = v[0] & v[1] & (v[2] | v[3]);
    o[1] = v[0] | v[1];
    o[2] = l;
    o[3] = ~l;
    o[4] = v[6] & v[7];
    o[6] = v[6] & v[10] & v[11];
    o[7] = v[12];
    if (v[8]) o = 16'h0000;
    o[5] = v[9];
    return o;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_logic();
    logic [15:0] vec [16] = '{16'h0003, 16'h0007, 16'h0019, 16'h0030,
      16'h0010, 16'h0000, 16'h00C0, 16'h0080, 16'h0C40, 16'h0C00,
      16'h1C00, 16'h0302, 16'h0202, 16'h2040, 16'h2000, 16'h0111};
    logic l;
    l = 1'b0;
    foreach (vec[i]) begin
      want <= vec[i];
      scans(3);
      if (vec[i][5]) l = 1'b0;
      else if (vec[i][4]) l = 1'b1;
      check({16'h0, seen}, {16'h0, expect_out(vec[i], l)});
      check({30'h0, tc_en, tc_pw},
            {30'h0, vec[i][6], vec[i][6] & vec[i][13]});
    end
    check({23'h0, tc_rf}, 32'h180);
    $display("logic test done");
  endtask

  task automatic t_power(input logic [15:0] p0, input logic kept);
    logic [31:0] r;
    // Outputs on before the supply drops, else the off check is idle
    want <= 16'h0311;
    wr(12'h400, {16'h0, p0});
    wr(12'h000, 32'h1);
    scans(2);
    wb(1'b0, 12'h004, 32'h0, r);
    check({31'h0, r[2]}, {31'h0, kept});
    check({16'h0, seen}, 32'h20);
    wr(12'h000, 32'h0);
    pwr_want <= 1'b0;
    repeat (10) @(posedge clk_i);
    check({16'h0, seen}, 32'h0);
    pwr_want <= 1'b1;
    repeat (600) @(posedge clk_i);
    wb(1'b0, 12'h098, 32'h0, r);
    check({31'h0, r[0]}, {31'h0, kept});
    wb(1'b0, 12'h080, 32'h0, r);
    check({31'h0, r[17]}, 32'h0);
    wb(1'b0, 12'h09C, 32'h0, r);
    check({31'h0, r[30]}, 32'h1);
    $display("power test done");
  endtask

  task automatic t_stack(input int n, input logic fault);
    logic [31:0] r;
    wr(12'h000, 32'h0);
    for (int i = 0; i < n; i++) begin
      wr(12'h400 + 12'(4 * i), 32'h1000);
    end
    wr(12'h400 + 12'(4 * n), 32'h9010);
    wr(12'h404 + 12'(4 * n), 32'h0);
    wr(12'h004, 32'h2);
    wr(12'h000, 32'h1);
    scans(2);
    wb(1'b0, 12'h004, 32'h0, r);
    check({31'h0, r[1]}, {31'h0, fault});
    $display("stack test done");
  endtask

  task automatic report_and_stop();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst <= 1'b0;
    repeat (600) @(posedge clk_i);
    foreach (prog[i]) begin
      wr(12'h400 + 12'(4 * i), {16'h0, prog[i]});
    end
    wb(1'b0, 12'h080, 32'h0, q);
    check(q, 32'h0);
    wr(12'h000, 32'h1);
    t_logic();
    t_power(16'h90FB, 1'b1);
    t_power(16'h90FC, 1'b0);
    t_stack(9, 1'b0);
    t_stack(10, 1'b1);
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule

// file: testbench/lre_field_io.sv
`timescale 1ns/10ps
// ----------------------------------------
// Field devices and supply sense
// ----------------------------------------
module lre_field_io (
  // Clock
  input wire logic clk_i,
  // Bench wishes
  input wire logic [15:0] want_i,
  input wire logic pwr_want_i,
  // Field side
  input wire logic [15:0] phys_i,
  output logic [15:0] in_o = 16'h0000,
  output logic pwr_ok_o = 1'b1,
  output logic [15:0] seen_o = 16'h0000
);
  // Switches move just after an edge; the sync chain sees clean levels
  always @(posedge clk_i) begin
    in_o <= want_i;
    pwr_ok_o <= pwr_want_i;
    seen_o <= phys_i;
  end
endmodule
